// ===== rtl/phs_regs.svh
// constants and functional notes for the parallel handshake port
// Functional notes
// - separate 16-bit input and output data buses, 32 lines in all.
// - port drives transfer request and uses it to start every transfer.
// - direction line high for input transfers, low for output, fixed polarity.
// - external request reported only when enabled; its level always readable.
// - two host-driven aux outputs and two peripheral-driven aux inputs.
// - data low-true by default; input and output high-true selectable separately.
// - request and acknowledge polarities each selectable.
// - full and pulse handshake modes chosen by static setting.
// - direction is set before the transfer request is asserted.
// - output data stays stable while request is set; peripheral samples then.
// - input bus latched on chosen acknowledge edge; peripheral holds data.
// - optional one-time ok check before first handshake; not-ok gives error 172.
// - interface reset pulses peripheral reset low at least 15 us.
// - interface reset clears the transfer request.
// - with clear option, reset zeroes output data; otherwise data unchanged.
// - interface reset clears the interrupt enable.
// - reset leaves aux outputs and direction line unchanged.
// - interrupts presented at one priority level, 3 through 6.
// - pulse mode: acknowledge pulse clears request and completes transfer.
// - full mode: done when request clear and acknowledge back ready.
// - mask bit 1 enables ready interrupt, bit 0 external request interrupt.
// - after one interrupt is logged, further ones blocked until re-enabled.
`ifndef PHS_REGS_SVH
`define PHS_REGS_SVH
`define PHS_DATA_W 16
`define PHS_FIFO_DEPTH 8
`define PHS_ERR_NOT_OK 8'hAC
`define PHS_MASK_EXT 0
`define PHS_MASK_RDY 1
`define PHS_RST_PULSE_NS 15000
`define PHS_CLK_NS 5
`define PHS_RST_CYCLES ((`PHS_RST_PULSE_NS + `PHS_CLK_NS - 1) / `PHS_CLK_NS)
`define PHS_PRIO_MIN 3'h3
`define PHS_PRIO_MAX 3'h6
`endif

// ===== rtl/phs_pkg.sv
// types for the parallel handshake port
`default_nettype none
package phs_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_check,
    st_dir,
    st_req,
    st_release,
    st_wait_ready
  } phs_state_type;
endpackage
`default_nettype wire

// ===== rtl/phs_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`include "phs_regs.svh"
`default_nettype none
module phs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } phs_fifo_state_type;
  phs_fifo_state_type st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr, do_rd;

  // handshake terms
  assign in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rp];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (do_wr) next_st.wp = AW'(st.wp + 1'b1);
    if (do_rd) next_st.rp = AW'(st.rp + 1'b1);
    if (do_wr && !do_rd) next_st.cnt = st.cnt + 1'b1;
    else if (do_rd && !do_wr) next_st.cnt = st.cnt - 1'b1;
    if (flush) next_st = '0;
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!rstn) st <= '0;
    else st <= next_st;
  end

  // storage array
  always_ff @(posedge clk_sys) begin
    if (do_wr) mem[st.wp] <= in_data;
  end
endmodule
`default_nettype wire

// ===== rtl/phs_port.sv
// parallel handshake port: direction, request, acknowledge, data and reset logic
`include "phs_regs.svh"
`default_nettype none
module phs_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // static configuration
  input wire logic handshake_mode_select,
  input wire logic cfg_din_high_true,
  input wire logic cfg_dout_high_true,
  input wire logic cfg_req_high_true,
  input wire logic cfg_ack_high_true,
  input wire logic cfg_capture_rising,
  input wire logic cfg_status_check,
  input wire logic cfg_status_high_ok,
  input wire logic cfg_dout_clear,
  input wire logic [2:0] cfg_irq_level,
  // host control
  input wire logic host_reset_write,
  input wire logic [7:0] host_reset_value,
  input wire logic [1:0] host_aux_set,
  input wire logic host_aux_write,
  input wire logic [1:0] host_irq_mask,
  input wire logic host_irq_enable_write,
  input wire logic host_read_start,
  // host output words
  input wire logic out_word_valid,
  output logic out_word_ready,
  input wire logic [`PHS_DATA_W-1:0] out_word_data,
  // host input words
  output logic in_word_valid,
  input wire logic in_word_ready,
  output logic [`PHS_DATA_W-1:0] in_word_data,
  // host status
  output logic busy,
  output logic error_flag,
  output logic [7:0] error_code,
  output logic external_request_level,
  output logic [1:0] periph_aux_level,
  output logic irq,
  output logic [2:0] irq_level,
  output logic [1:0] irq_cause,
  // peripheral pins
  input wire logic [`PHS_DATA_W-1:0] input_data_bus,
  output logic [`PHS_DATA_W-1:0] output_data_bus,
  output logic transfer_request_line,
  input wire logic peripheral_ack_line,
  output logic direction_line,
  input wire logic external_request_line,
  output logic host_aux_out_a,
  output logic host_aux_out_b,
  input wire logic periph_aux_in_a,
  input wire logic periph_aux_in_b,
  input wire logic peripheral_ok_line,
  output logic periph_reset_n
);
  localparam logic [13:0] RST_CNT = 14'(`PHS_RST_CYCLES);

  typedef struct packed {
    phs_pkg::phs_state_type fsm;
    logic req;
    logic dir;
    logic is_input;
    logic ack_prev;
    logic checked;
    logic [`PHS_DATA_W-1:0] dout;
    logic [`PHS_DATA_W-1:0] cap;
    logic cap_valid;
    logic [1:0] aux;
    logic [1:0] mask;
    logic ien;
    logic [1:0] cause;
    logic err;
    logic [13:0] rst_cnt;
  } phs_port_state_type;

  phs_port_state_type st, next_st;
  logic ack_set, ack_rise, ack_fall, cap_edge, ok_now, ifc_reset;
  logic start_ok, check_due;
  logic fifo_valid, fifo_pop, rdy_event, ext_event;
  logic [`PHS_DATA_W-1:0] fifo_data;

  // output words wait in the fifo; the handshake engine drains them
  phs_fifo #(
    .WIDTH(`PHS_DATA_W),
    .DEPTH(`PHS_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(1'b0),
    .in_valid(out_word_valid),
    .in_ready(out_word_ready),
    .in_data(out_word_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // acknowledge decoding with selectable polarity
  assign ack_set = peripheral_ack_line ~^ cfg_ack_high_true;
  assign ack_rise = peripheral_ack_line && !st.ack_prev;
  assign ack_fall = !peripheral_ack_line && st.ack_prev;
  assign cap_edge = cfg_capture_rising ? ack_rise : ack_fall;
  assign ok_now = peripheral_ok_line ~^ cfg_status_high_ok;
  assign ifc_reset = host_reset_write && (host_reset_value != 8'h00);
  // no transfer starts during the reset pulse or after a failed ok check
  assign start_ok = (st.rst_cnt == 14'h0000) && !st.err && !ifc_reset;
  assign check_due = cfg_status_check && !st.checked;
  // a word leaves the fifo only once its transfer is sure to run; output words go first
  assign fifo_pop = fifo_valid && !ifc_reset && (((st.fsm == phs_pkg::st_idle) && start_ok && !check_due)
    || ((st.fsm == phs_pkg::st_check) && ok_now && !st.is_input));
  assign ext_event = !external_request_line;
  assign rdy_event = (st.fsm == phs_pkg::st_idle);

  // next state
  always_comb begin
    next_st = st;
    next_st.ack_prev = peripheral_ack_line;
    if (st.rst_cnt != 14'h0000) next_st.rst_cnt = st.rst_cnt - 14'h0001;
    if (host_aux_write) next_st.aux = host_aux_set;
    if (host_irq_enable_write) begin
      next_st.mask = host_irq_mask;
      next_st.ien = 1'b1;
      next_st.cause = 2'b00;
    end
    if (in_word_valid && in_word_ready) next_st.cap_valid = 1'b0;
    // capture on the chosen acknowledge edge, whether it leads or trails the acknowledge
    if (st.is_input && cap_edge && ((st.fsm == phs_pkg::st_req) || (st.fsm == phs_pkg::st_wait_ready))) begin
      next_st.cap = cfg_din_high_true ? input_data_bus : ~input_data_bus;
      next_st.cap_valid = 1'b1;
    end
    unique case (st.fsm)
      phs_pkg::st_idle: begin
        if (start_ok && (fifo_valid || host_read_start)) begin
          next_st.is_input = !fifo_valid; // output words take priority
          if (check_due) next_st.fsm = phs_pkg::st_check;
          else next_st.fsm = phs_pkg::st_dir;
        end
      end
      phs_pkg::st_check: begin
        if (ok_now) begin
          next_st.checked = 1'b1;
          next_st.fsm = phs_pkg::st_dir;
        end else begin
          next_st.err = 1'b1;
          next_st.fsm = phs_pkg::st_idle;
        end
      end
      phs_pkg::st_dir: begin
        next_st.dir = st.is_input;
        if (st.dir == st.is_input) begin
          next_st.req = 1'b1;
          next_st.fsm = phs_pkg::st_req;
        end
      end
      phs_pkg::st_req: begin
        // full: ack set ends the request; pulse: the capture edge for input, ack set for output
        if (handshake_mode_select ? ack_set : (st.is_input ? cap_edge : ack_set)) begin
          next_st.req = 1'b0;
          next_st.fsm = handshake_mode_select ? phs_pkg::st_wait_ready : phs_pkg::st_release;
        end
      end
      phs_pkg::st_wait_ready: begin
        if (!ack_set) next_st.fsm = phs_pkg::st_release;
      end
      phs_pkg::st_release: begin
        next_st.fsm = phs_pkg::st_idle;
      end
      default: next_st.fsm = phs_pkg::st_idle;
    endcase
    // the popped word drives the data lines until the next one
    if (fifo_pop) next_st.dout = fifo_data;
    // interrupt logging blocks later ones until re-enabled
    if (st.ien) begin
      if (st.mask[`PHS_MASK_RDY] && rdy_event) next_st.cause[`PHS_MASK_RDY] = 1'b1;
      if (st.mask[`PHS_MASK_EXT] && ext_event) next_st.cause[`PHS_MASK_EXT] = 1'b1;
      if ((st.mask[`PHS_MASK_RDY] && rdy_event) || (st.mask[`PHS_MASK_EXT] && ext_event))
        next_st.ien = 1'b0;
    end
    // interface reset; aux and direction kept
    if (ifc_reset) begin
      next_st.fsm = phs_pkg::st_idle;
      next_st.req = 1'b0;
      next_st.ien = 1'b0;
      next_st.err = 1'b0;
      next_st.checked = 1'b0;
      next_st.rst_cnt = RST_CNT;
      if (cfg_dout_clear) next_st.dout = '0;
      next_st.dir = st.dir;
      next_st.aux = st.aux;
    end
  end

  // state register; power-on acts as an interface reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= '0;
      st.rst_cnt <= RST_CNT;
    end else begin
      st <= next_st;
    end
  end

  // pin drive
  assign output_data_bus = cfg_dout_high_true ? st.dout : ~st.dout;
  assign transfer_request_line = st.req ~^ cfg_req_high_true;
  assign direction_line = st.dir;
  assign host_aux_out_a = st.aux[0];
  assign host_aux_out_b = st.aux[1];
  assign periph_reset_n = (st.rst_cnt == 14'h0000);

  // host side status
  assign in_word_valid = st.cap_valid;
  assign in_word_data = st.cap;
  assign busy = (st.fsm != phs_pkg::st_idle);
  assign error_flag = st.err;
  assign error_code = st.err ? `PHS_ERR_NOT_OK : 8'h00;
  assign external_request_level = external_request_line;
  assign periph_aux_level = {periph_aux_in_b, periph_aux_in_a};
  assign irq = |st.cause;
  assign irq_cause = st.cause;
  assign irq_level = (cfg_irq_level < `PHS_PRIO_MIN) ? `PHS_PRIO_MIN :
    (cfg_irq_level > `PHS_PRIO_MAX) ? `PHS_PRIO_MAX : cfg_irq_level;
endmodule
`default_nettype wire

// ===== verif/phs_port_monitor.sv
// concurrent checks on the parallel handshake port
`default_nettype none
module phs_port_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // host side
  input wire logic cfg_req_high_true,
  input wire logic cfg_ack_high_true,
  input wire logic cfg_status_check,
  input wire logic host_reset_write,
  input wire logic [7:0] host_reset_value,
  input wire logic host_aux_write,
  input wire logic busy,
  input wire logic error_flag,
  input wire logic [7:0] error_code,
  // peripheral pins
  input wire logic [15:0] output_data_bus,
  input wire logic transfer_request_line,
  input wire logic peripheral_ack_line,
  input wire logic direction_line,
  input wire logic host_aux_out_a,
  input wire logic host_aux_out_b,
  input wire logic periph_reset_n
);
  logic req_set;
  logic ack_set;
  logic host_rst;
  logic [11:0] low_cnt;
  // handshake lines in their set state
  assign req_set = transfer_request_line == cfg_req_high_true;
  assign ack_set = peripheral_ack_line == cfg_ack_high_true;
  assign host_rst = host_reset_write && host_reset_value != 8'h00;
  // counts low cycles of the peripheral reset pulse
  always_ff @(posedge clk_sys) begin
    low_cnt <= (!rstn || periph_reset_n) ? 12'h000 : low_cnt + 12'h001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_req_up; !req_set ##1 req_set; endsequence
  sequence s_out_held; req_set ##1 req_set && !direction_line; endsequence
  sequence s_ack_seen; req_set && ack_set; endsequence
  dir_first_a: assert property (s_req_up |-> $stable(direction_line))
    else $error("direction moved at request");
  data_hold_a: assert property (s_out_held |-> $stable(output_data_bus))
    else $error("output data moved");
  ack_clears_a: assert property (s_ack_seen |-> ##[1:3] !req_set)
    else $error("request not cleared");
  pulse_len_a: assert property ($rose(periph_reset_n) |-> low_cnt >= 12'hBB8)
    else $error("reset pulse too short");
  quiet_reset_a: assert property (!periph_reset_n |-> !req_set)
    else $error("request during reset");
  host_reset_a: assert property (host_rst |-> ##[1:2] !periph_reset_n)
    else $error("no reset pulse");
  reset_keeps_a: assert property (host_rst && !host_aux_write && !busy |=>
    $stable({host_aux_out_a, host_aux_out_b, direction_line})) else $error("lines moved on reset");
  error_code_a: assert property (error_flag |-> cfg_status_check && error_code == 8'hAC)
    else $error("bad error report");
endmodule
bind phs_port phs_port_monitor u_phs_port_monitor (.clk_sys, .rstn, .cfg_req_high_true,
  .cfg_ack_high_true, .cfg_status_check, .host_reset_write, .host_reset_value, .host_aux_write,
  .busy, .error_flag, .error_code, .output_data_bus, .transfer_request_line, .peripheral_ack_line,
  .direction_line, .host_aux_out_a, .host_aux_out_b, .periph_reset_n);
`default_nettype wire

// ===== verif/phs_periph_model.sv
// peripheral model answering each request with an acknowledge pulse
`default_nettype none
module phs_periph_model (
  // clock and handshake
  input wire logic clk_sys,
  input wire logic req_hi,
  input wire logic ack_hi,
  input wire logic transfer_request_line,
  output logic peripheral_ack_line,
  // offered input word
  input wire logic [15:0] word,
  output logic [15:0] input_data_bus
);
  logic ack_set = 1'b0;
  assign peripheral_ack_line = ack_set ~^ ack_hi;
  // data valid from request until after acknowledge, inverted otherwise
  initial begin
    input_data_bus = 16'hFFFF;
    forever begin
      @(negedge clk_sys);
      if (transfer_request_line == req_hi) begin
        input_data_bus = word;
        repeat ($urandom % 4) @(negedge clk_sys);
        ack_set = 1'b1;
        repeat (2) @(negedge clk_sys);
        ack_set = 1'b0;
        @(negedge clk_sys);
        input_data_bus = ~word;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_phs_port.sv
// self-checking bench for the parallel handshake port
`default_nettype none
module tb_phs_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic c = 1'b0;
  logic chk = 1'b0;
  logic ok = 1'b1;
  logic rw = 1'b0;
  logic aw = 1'b0;
  logic rd = 1'b0;
  logic ov = 1'b0;
  logic rq_d = 1'b0;
  logic [1:0] aux = 2'h0;
  logic [3:0] rnd = 4'h0;
  logic [15:0] od = 16'h0000;
  logic [15:0] pword = 16'h0000;
  logic [16:0] expq[$];
  int mismatches = 0;
  int num_checks = 0;
  logic ordy, ivld, bsy, eflag, req, ack, dir, aoa, aob, prn;
  logic ext_lvl, irqo;
  logic [1:0] aux_lvl, icause;
  logic [2:0] irq_lvl;
  logic [7:0] ecode;
  logic [15:0] iword, obus, ibus;
  phs_port u_phs_port (.clk_sys, .rstn, .handshake_mode_select(c), .cfg_din_high_true(c),
    .cfg_dout_high_true(c), .cfg_req_high_true(c), .cfg_ack_high_true(c), .cfg_capture_rising(c),
    .cfg_status_check(chk), .cfg_status_high_ok(1'b1), .cfg_dout_clear(1'b1), .cfg_irq_level(3'h4),
    .host_reset_write(rw), .host_reset_value(8'h01), .host_aux_set(aux), .host_aux_write(aw),
    .host_irq_mask(aux), .host_irq_enable_write(aw), .host_read_start(rd), .out_word_valid(ov),
    .out_word_ready(ordy), .out_word_data(od), .in_word_valid(ivld), .in_word_ready(rnd[3]),
    .in_word_data(iword), .busy(bsy), .error_flag(eflag), .error_code(ecode),
    .external_request_level(ext_lvl), .periph_aux_level(aux_lvl), .irq(irqo), .irq_level(irq_lvl),
    .irq_cause(icause),
    .input_data_bus(ibus), .output_data_bus(obus), .transfer_request_line(req),
    .peripheral_ack_line(ack), .direction_line(dir), .external_request_line(rnd[0]),
    .host_aux_out_a(aoa), .host_aux_out_b(aob), .periph_aux_in_a(rnd[1]), .periph_aux_in_b(rnd[2]),
    .peripheral_ok_line(ok), .periph_reset_n(prn));
  phs_periph_model u_phs_periph_model (.clk_sys, .req_hi(c), .ack_hi(c), .transfer_request_line(req),
    .peripheral_ack_line(ack), .word(pword), .input_data_bus(ibus));
  // clock
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // side outputs against the standing side wires; then new stalls, and the oldest note when a word shows
  always @(negedge clk_sys) begin
    cmp({11'h000, irq_lvl, ext_lvl, aux_lvl}, {11'h000, 3'h4, rnd[0], rnd[2:1]});
    rnd = 4'($urandom);
    rq_d <= req;
    if (ivld === 1'b1 && rnd[3] && expq.size() != 0)
      cmp({dir, iword}, expq.pop_front());
    else if (req === c && rq_d !== c && expq.size() != 0 && !expq[0][16])
      cmp({dir, obus}, expq.pop_front());
  end
  // wait until notes are used up, port idle and out of reset
  task automatic settle();
    for (int t = 0; t < 4000 && (expq.size() != 0 || bsy !== 1'b0 || prn !== 1'b1); t++)
      @(negedge clk_sys);
    if (expq.size() != 0 || bsy !== 1'b0 || prn !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t port did not settle", $time);
    end
  endtask
  task automatic send(input logic [15:0] w);
    expq.push_back({1'b0, c ? w : ~w});
    od = w;
    ov = 1'b1;
    while (ordy !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic fetch(input logic [15:0] w);
    expq.push_back({1'b1, c ? w : ~w});
    pword = w;
    rd = 1'b1;
    for (int t = 0; t < 50 && bsy !== 1'b1; t++) @(negedge clk_sys);
    rd = 1'b0;
    settle();
  endtask
  task automatic final_report();
    if (expq.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // both modes and polarities, then a failing ok check after a host reset
  initial begin
    void'($urandom(32'hEA671318));
    for (int k = 0; k < 2; k++) begin
      c = k[0];
      rstn = 1'b0;
      repeat (3) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      cmp({prn, obus}, {1'b0, c ? 16'h0000 : 16'hFFFF});
      settle();
      for (int i = 0; i < 12; i++) send(16'($urandom));
      ov = 1'b0;
      settle();
      for (int i = 0; i < 4; i++) fetch(16'($urandom));
    end
    aux = 2'h2;
    aw = 1'b1;
    chk = 1'b1;
    ok = 1'b0;
    @(negedge clk_sys);
    aw = 1'b0;
    rw = 1'b1;
    @(negedge clk_sys);
    rw = 1'b0;
    @(negedge clk_sys);
    cmp({13'h0, dir, aob, aoa, prn}, {13'h0, 1'b1, aux, 1'b0});
    settle();
    send(16'hA5C3);
    ov = 1'b0;
    for (int t = 0; t < 50 && eflag !== 1'b1; t++) @(negedge clk_sys);
    cmp({8'h00, eflag, ecode}, {8'h00, 1'b1, 8'hAC});
    cmp({14'h0000, irqo, icause}, {14'h0000, 1'b1, 2'b10});
    cmp(17'(expq.size()), 17'h00001);
    expq.delete();
    final_report();
  end
  // cut a hang short at several times the expected run
  initial begin
    #200us;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
